// >>> core/instruction_cycle_timing.sv
// Execution-time sequencer: takes a classified instruction and stays busy
// for exactly as many processor clocks as that instruction costs.
// Assumes one request at a time from the decoder, offered only while idle.
//
// Summary of operation
// - Add, add-with-carry and and of an immediate into the accumulator take 3 cycles for bytes, 4 for words.
// - Flagged memory figures on the 8-bit bus are byte-transfer figures.
// - Word operations with a memory operand on flagged entries add 4 cycles per memory transfer on the 8-bit bus.
// - A direct near call takes 15 cycles on the 16-bit bus and 19 on the 8-bit bus.
// - An indirect near call takes 13/19 (register/memory) cycles on the 16-bit bus and 17/27 on the 8-bit bus.
// - The overflow trap takes 48 cycles when taken and 4 when not.
// - The bound check takes between 33 and 35 cycles on both buses.
`timescale 1ns/10ps
`default_nettype none

module instruction_cycle_timing #(
  parameter logic BUS8 = 1'b0  // 1 selects the 8-bit external bus variant
) (
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  // Request from the decoder
  input  wire logic                                  start,
  input  wire cycle_timing_pkg::req_t                req,
  // Status towards the decoder
  output logic                                       busy,
  output logic                                       done,
  output logic                                       trap_taken,
  output logic      [cycle_timing_pkg::CNT_W-1:0]    cycles
);

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } phase_t;

  typedef struct packed {
    phase_t                             phase;
    logic                               busy;
    logic                               done;
    logic                               trap_taken;
    logic [cycle_timing_pkg::CNT_W-1:0] cycles;
  } seq_state_t;

  seq_state_t st_q;
  seq_state_t st_d;

  logic [cycle_timing_pkg::CNT_W-1:0] remain_q;
  logic [cycle_timing_pkg::CNT_W-1:0] cost;
  logic                               accept;

  // Pick a figure by variant
  function automatic logic [cycle_timing_pkg::CNT_W-1:0] by_bus(
    input logic                               narrow,
    input logic [cycle_timing_pkg::CNT_W-1:0] wide_val,
    input logic [cycle_timing_pkg::CNT_W-1:0] narrow_val
  );
    by_bus = narrow ? narrow_val : wide_val;
  endfunction : by_bus

  // Pick a figure by register or memory operand
  function automatic logic [cycle_timing_pkg::CNT_W-1:0] by_mem(
    input logic                               mem,
    input logic [cycle_timing_pkg::CNT_W-1:0] reg_val,
    input logic [cycle_timing_pkg::CNT_W-1:0] mem_val
  );
    by_mem = mem ? mem_val : reg_val;
  endfunction : by_mem

  // Entries whose narrow-bus memory figure is a byte-transfer figure
  function automatic logic word_flagged(input cycle_timing_pkg::op_t op);
    case (op)
      cycle_timing_pkg::OP_ALU_IMM_RM,
      cycle_timing_pkg::OP_ALU_RM_REG,
      cycle_timing_pkg::OP_CMP_IMM_RM,
      cycle_timing_pkg::OP_STR_COMPARE,
      cycle_timing_pkg::OP_DEC_RM,
      cycle_timing_pkg::OP_INC_RM,
      cycle_timing_pkg::OP_DIV_MEM_WORD,
      cycle_timing_pkg::OP_IN_FIXED,
      cycle_timing_pkg::OP_IN_VARIABLE: word_flagged = 1'b1;
      default:                          word_flagged = 1'b0;
    endcase
  endfunction : word_flagged

  // Base figure for one request, byte case on flagged entries
  function automatic logic [cycle_timing_pkg::CNT_W-1:0] base_cost(
    input cycle_timing_pkg::req_t r,
    input logic                   narrow
  );
    logic [cycle_timing_pkg::CNT_W-1:0] bext;
    bext = {{(cycle_timing_pkg::CNT_W-cycle_timing_pkg::BEXT_W){1'b0}}, r.bound_extra};
    case (r.op)
      cycle_timing_pkg::OP_ASCII_ADJ_ADD:   base_cost = cycle_timing_pkg::C_AAA;
      cycle_timing_pkg::OP_ASCII_ADJ_DIV:   base_cost = cycle_timing_pkg::C_AAD;
      cycle_timing_pkg::OP_ASCII_ADJ_MUL:   base_cost = cycle_timing_pkg::C_AAM;
      cycle_timing_pkg::OP_ASCII_ADJ_SUB:   base_cost = cycle_timing_pkg::C_AAS;
      // Same on both buses, accumulator only so no transfer penalty
      cycle_timing_pkg::OP_ALU_IMM_ACC:     base_cost = r.word ? cycle_timing_pkg::C_IMM_ACC_W
                                                               : cycle_timing_pkg::C_IMM_ACC_B;
      cycle_timing_pkg::OP_ALU_IMM_RM:      base_cost = by_mem(r.mem, cycle_timing_pkg::C_IMM_RM_R,
                                                               cycle_timing_pkg::C_IMM_RM_M);
      cycle_timing_pkg::OP_ALU_RM_REG,
      cycle_timing_pkg::OP_CMP_IMM_RM:      base_cost = by_mem(r.mem, cycle_timing_pkg::C_RM_REG_R,
                                                               cycle_timing_pkg::C_RM_REG_M);
      // Extra cycles above the floor are clamped to the documented ceiling
      cycle_timing_pkg::OP_BOUND_CHECK: begin
        base_cost = cycle_timing_pkg::C_BOUND_MIN + bext;
        if (base_cost > cycle_timing_pkg::C_BOUND_MAX) begin
          base_cost = cycle_timing_pkg::C_BOUND_MAX;
        end
      end
      cycle_timing_pkg::OP_CALL_FAR_DIRECT: base_cost = by_bus(narrow, cycle_timing_pkg::C_CALLF_W,
                                                               cycle_timing_pkg::C_CALLF_N);
      cycle_timing_pkg::OP_CALL_NEAR_DIRECT: base_cost = by_bus(narrow, cycle_timing_pkg::C_CALLN_W,
                                                                cycle_timing_pkg::C_CALLN_N);
      cycle_timing_pkg::OP_CALL_FAR_INDIRECT: base_cost = by_bus(narrow, cycle_timing_pkg::C_CALLFI_W,
                                                                 cycle_timing_pkg::C_CALLFI_N);
      cycle_timing_pkg::OP_CALL_NEAR_INDIRECT: begin
        base_cost = by_bus(narrow,
                           by_mem(r.mem, cycle_timing_pkg::C_CALLI_R_W, cycle_timing_pkg::C_CALLI_M_W),
                           by_mem(r.mem, cycle_timing_pkg::C_CALLI_R_N, cycle_timing_pkg::C_CALLI_M_N));
      end
      cycle_timing_pkg::OP_SIMPLE:          base_cost = cycle_timing_pkg::C_SIMPLE;
      cycle_timing_pkg::OP_STR_COMPARE:     base_cost = cycle_timing_pkg::C_CMPS;
      cycle_timing_pkg::OP_CONVERT_WORD:    base_cost = cycle_timing_pkg::C_CWD;
      cycle_timing_pkg::OP_DECIMAL_ADJ:     base_cost = cycle_timing_pkg::C_DAA;
      cycle_timing_pkg::OP_INC_DEC_REG:     base_cost = cycle_timing_pkg::C_INCDEC_R;
      cycle_timing_pkg::OP_DEC_RM:          base_cost = by_mem(r.mem, cycle_timing_pkg::C_INCDEC_R,
                                                               by_bus(narrow, cycle_timing_pkg::C_DEC_M_W,
                                                                      cycle_timing_pkg::C_DEC_M_N));
      cycle_timing_pkg::OP_INC_RM:          base_cost = by_mem(r.mem, cycle_timing_pkg::C_INCDEC_R,
                                                               cycle_timing_pkg::C_INC_M);
      cycle_timing_pkg::OP_DIV_MEM_BYTE:    base_cost = cycle_timing_pkg::C_DIV_MB;
      cycle_timing_pkg::OP_DIV_MEM_WORD:    base_cost = cycle_timing_pkg::C_DIV_MW;
      cycle_timing_pkg::OP_DIV_REG_BYTE:    base_cost = cycle_timing_pkg::C_DIV_RB;
      cycle_timing_pkg::OP_DIV_REG_WORD:    base_cost = cycle_timing_pkg::C_DIV_RW;
      cycle_timing_pkg::OP_IN_FIXED:        base_cost = cycle_timing_pkg::C_IN_FIXED;
      cycle_timing_pkg::OP_IN_VARIABLE:     base_cost = cycle_timing_pkg::C_IN_VAR;
      cycle_timing_pkg::OP_INT_TYPED:       base_cost = cycle_timing_pkg::C_INT_TYPED;
      cycle_timing_pkg::OP_INT_BREAK:       base_cost = cycle_timing_pkg::C_INT_BREAK;
      cycle_timing_pkg::OP_INT_OVERFLOW:    base_cost = r.ovf ? cycle_timing_pkg::C_INTO_TAKEN
                                                              : cycle_timing_pkg::C_INTO_SKIP;
      cycle_timing_pkg::OP_INT_RETURN:      base_cost = cycle_timing_pkg::C_IRET;
      default:                              base_cost = cycle_timing_pkg::C_SIMPLE;
    endcase
  endfunction : base_cost

  // Narrow bus pays per word transfer on flagged memory forms only;
  // register forms move nothing on the bus, so they keep the base figure
  function automatic logic [cycle_timing_pkg::CNT_W-1:0] word_penalty(
    input cycle_timing_pkg::req_t r,
    input logic                   narrow
  );
    logic [cycle_timing_pkg::CNT_W-1:0] xfers;
    xfers = {{(cycle_timing_pkg::CNT_W-cycle_timing_pkg::XFER_W){1'b0}}, r.mem_xfers};
    if (narrow && r.word && r.mem && word_flagged(r.op)) begin
      word_penalty = cycle_timing_pkg::CNT_W'(xfers * cycle_timing_pkg::C_WORD_XFER);
    end else begin
      word_penalty = '0;
    end
  endfunction : word_penalty

  assign cost   = base_cost(req, BUS8) + word_penalty(req, BUS8);
  assign accept = start && (st_q.phase == ST_IDLE);

  // Busy time is held by the shared down-counter
  cycle_countdown #(
    .CNT_W (cycle_timing_pkg::CNT_W)
  ) u_countdown (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .load     (accept),
    .load_val (cost),
    .remain_q (remain_q)
  );

  // Sequencing: busy for exactly cost cycles, done one cycle after the last
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    case (st_q.phase)
      ST_IDLE: begin
        if (accept) begin
          st_d.phase      = ST_RUN;
          st_d.busy       = 1'b1;
          st_d.cycles     = cost;
          st_d.trap_taken = (req.op == cycle_timing_pkg::OP_INT_OVERFLOW) && req.ovf;
        end
      end
      ST_RUN: begin
        // Requests during the run are ignored, the decoder must wait
        if (remain_q == cycle_timing_pkg::CNT_ONE) begin
          st_d.phase = ST_IDLE;
          st_d.busy  = 1'b0;
          st_d.done  = 1'b1;
        end
      end
      default: begin
        st_d.phase = ST_IDLE;
        st_d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{phase: ST_IDLE, busy: 1'b0, done: 1'b0, trap_taken: 1'b0, cycles: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign busy       = st_q.busy;
  assign done       = st_q.done;
  assign trap_taken = st_q.trap_taken;
  assign cycles     = st_q.cycles;

endmodule : instruction_cycle_timing

`default_nettype wire

// >>> core/cycle_timing_pkg.sv
// Package for the instruction cycle-timing unit: operation codes, request
// carrier and the per-operation clock-cycle figures for both bus variants.
// Assumes the decoder ahead of the unit classifies each instruction into op_t.
package cycle_timing_pkg;

  // Width of a cycle count; largest figure plus word penalties fits easily
  localparam int CNT_W = 8;
  localparam int XFER_W = 3;
  localparam int BEXT_W = 2;

  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Operation classes the unit can time
  typedef enum logic [5:0] {
    OP_ASCII_ADJ_ADD,
    OP_ASCII_ADJ_DIV,
    OP_ASCII_ADJ_MUL,
    OP_ASCII_ADJ_SUB,
    OP_ALU_IMM_ACC,     // add, add-with-carry, and, compare into accumulator
    OP_ALU_IMM_RM,      // add, add-with-carry, and immediate to reg/mem
    OP_ALU_RM_REG,      // add, add-with-carry, and, compare reg/mem forms
    OP_CMP_IMM_RM,
    OP_BOUND_CHECK,
    OP_CALL_FAR_DIRECT,
    OP_CALL_NEAR_DIRECT,
    OP_CALL_FAR_INDIRECT,
    OP_CALL_NEAR_INDIRECT,
    OP_SIMPLE,          // flag ops, sign extend, prefixes, halt
    OP_STR_COMPARE,
    OP_CONVERT_WORD,
    OP_DECIMAL_ADJ,
    OP_INC_DEC_REG,
    OP_DEC_RM,
    OP_INC_RM,
    OP_DIV_MEM_BYTE,
    OP_DIV_MEM_WORD,
    OP_DIV_REG_BYTE,
    OP_DIV_REG_WORD,
    OP_IN_FIXED,
    OP_IN_VARIABLE,
    OP_INT_TYPED,
    OP_INT_BREAK,
    OP_INT_OVERFLOW,
    OP_INT_RETURN
  } op_t;

  // One timing request from the decoder
  typedef struct packed {
    op_t               op;
    logic              word;        // 16-bit operand
    logic              mem;         // memory operand (else register)
    logic              ovf;         // overflow flag as seen by the trap check
    logic [BEXT_W-1:0] bound_extra; // extra bound-check cycles, 0..2
    logic [XFER_W-1:0] mem_xfers;   // memory transfers of the instruction
  } req_t;

  // Cycle figures: 16-bit-bus variant (_W) and 8-bit-bus variant (_N); C_IMM_ACC_B/_W are byte/word, same on both buses
  localparam logic [CNT_W-1:0] C_AAA        = 8'h08;
  localparam logic [CNT_W-1:0] C_AAD        = 8'h0f;
  localparam logic [CNT_W-1:0] C_AAM        = 8'h13;
  localparam logic [CNT_W-1:0] C_AAS        = 8'h07;
  localparam logic [CNT_W-1:0] C_IMM_ACC_B  = 8'h03;
  localparam logic [CNT_W-1:0] C_IMM_ACC_W  = 8'h04;
  localparam logic [CNT_W-1:0] C_IMM_RM_R   = 8'h04;
  localparam logic [CNT_W-1:0] C_IMM_RM_M   = 8'h10;
  localparam logic [CNT_W-1:0] C_RM_REG_R   = 8'h03;
  localparam logic [CNT_W-1:0] C_RM_REG_M   = 8'h0a;
  localparam logic [CNT_W-1:0] C_BOUND_MIN  = 8'h21;
  localparam logic [CNT_W-1:0] C_BOUND_MAX  = 8'h23;
  localparam logic [CNT_W-1:0] C_CALLF_W    = 8'h17;
  localparam logic [CNT_W-1:0] C_CALLF_N    = 8'h1f;
  localparam logic [CNT_W-1:0] C_CALLN_W    = 8'h0f;
  localparam logic [CNT_W-1:0] C_CALLN_N    = 8'h13;
  localparam logic [CNT_W-1:0] C_CALLFI_W   = 8'h26;
  localparam logic [CNT_W-1:0] C_CALLFI_N   = 8'h36;
  localparam logic [CNT_W-1:0] C_CALLI_R_W  = 8'h0d;
  localparam logic [CNT_W-1:0] C_CALLI_M_W  = 8'h13;
  localparam logic [CNT_W-1:0] C_CALLI_R_N  = 8'h11;
  localparam logic [CNT_W-1:0] C_CALLI_M_N  = 8'h1b;
  localparam logic [CNT_W-1:0] C_SIMPLE     = 8'h02;
  localparam logic [CNT_W-1:0] C_CMPS       = 8'h16;
  localparam logic [CNT_W-1:0] C_CWD        = 8'h04;
  localparam logic [CNT_W-1:0] C_DAA        = 8'h04;
  localparam logic [CNT_W-1:0] C_INCDEC_R   = 8'h03;
  localparam logic [CNT_W-1:0] C_DEC_M_W    = 8'h0e;
  localparam logic [CNT_W-1:0] C_DEC_M_N    = 8'h0f;
  localparam logic [CNT_W-1:0] C_INC_M      = 8'h0f;
  localparam logic [CNT_W-1:0] C_DIV_MB     = 8'h23;
  localparam logic [CNT_W-1:0] C_DIV_MW     = 8'h2c;
  localparam logic [CNT_W-1:0] C_DIV_RB     = 8'h1d;
  localparam logic [CNT_W-1:0] C_DIV_RW     = 8'h26;
  localparam logic [CNT_W-1:0] C_IN_FIXED   = 8'h0a;
  localparam logic [CNT_W-1:0] C_IN_VAR     = 8'h08;
  localparam logic [CNT_W-1:0] C_INT_TYPED  = 8'h2f;
  localparam logic [CNT_W-1:0] C_INT_BREAK  = 8'h2d;
  localparam logic [CNT_W-1:0] C_INTO_TAKEN = 8'h30;
  localparam logic [CNT_W-1:0] C_INTO_SKIP  = 8'h04;
  localparam logic [CNT_W-1:0] C_IRET       = 8'h1c;

  // Word penalty per memory transfer on the 8-bit bus
  localparam logic [CNT_W-1:0] C_WORD_XFER  = 8'h04;

endpackage : cycle_timing_pkg

// >>> core/cycle_countdown.sv
// Down-counter that holds an instruction busy for a loaded number of cycles.
// Assumes load is only raised while the counter stands at zero.
`timescale 1ns/10ps
`default_nettype none

module cycle_countdown #(
  parameter int CNT_W = cycle_timing_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Load
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  // Remaining cycles
  output logic      [CNT_W-1:0] remain_q
);

  typedef struct packed {
    logic [CNT_W-1:0] remain;
  } cnt_state_t;

  cnt_state_t st_q;
  cnt_state_t st_d;

  // Load wins; otherwise count down to zero and rest there
  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.remain = load_val;
    end else if (st_q.remain != '0) begin
      st_d.remain = st_q.remain - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign remain_q = st_q.remain;

endmodule : cycle_countdown

`default_nettype wire

// >>> dv/instruction_cycle_timing_asserts.sv
// Checker for the cycle-timing sequencer: accepted request against busy length and cycle figure.
// Assumes it is bound to every instance of the top module and sees its ports only.
`timescale 1ns/10ps
`default_nettype none

module instruction_cycle_timing_asserts #(
  parameter logic BUS8 = 1'b0
) (
  // Clock and reset
  input wire logic                                 clk_sys,
  input wire logic                                 rst_n,
  // Request
  input wire logic                                 start,
  input wire cycle_timing_pkg::req_t               req,
  // Status
  input wire logic                                 busy,
  input wire logic                                 done,
  input wire logic                                 trap_taken,
  input wire logic [cycle_timing_pkg::CNT_W-1:0]   cycles
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  cycle_timing_pkg::req_t req_q;
  logic [7:0]             len_q;

  // Copy of the accepted request; run length of busy for the duration check
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
      len_q <= 8'h00;
    end else begin
      if (start && !busy) begin
        req_q <= req;
      end
      len_q <= busy ? len_q + 8'h01 : 8'h00;
    end
  end

  // Request taken only while idle
  sequence s_accept;
    start && !busy;
  endsequence
  sequence s_three;
    busy[*3] ##1 (done && !busy);
  endsequence
  sequence s_four;
    busy[*4] ##1 (done && !busy);
  endsequence

  a_acc_byte: assert property (s_accept ##0 (req.op == cycle_timing_pkg::OP_ALU_IMM_ACC && !req.word)
    |=> cycles == 8'h03 ##0 s_three) else $error("byte accumulator op not 3 cycles");
  a_acc_word: assert property (s_accept ##0 (req.op == cycle_timing_pkg::OP_ALU_IMM_ACC && req.word)
    |=> cycles == 8'h04 ##0 s_four) else $error("word accumulator op not 4 cycles");
  a_byte_figure: assert property (s_accept ##0 (req.op == cycle_timing_pkg::OP_ALU_RM_REG && req.mem && !req.word)
    |=> cycles == 8'h0a) else $error("byte memory figure wrong");
  a_word_penalty: assert property (s_accept ##0 (req.op == cycle_timing_pkg::OP_ALU_IMM_RM && req.mem)
    |=> cycles == 8'h10 + ((BUS8 && req_q.word) ? {3'h0, req_q.mem_xfers, 2'h0} : 8'h00))
    else $error("word transfer penalty wrong");
  a_call_direct: assert property (s_accept ##0 req.op == cycle_timing_pkg::OP_CALL_NEAR_DIRECT
    |=> cycles == (BUS8 ? 8'h13 : 8'h0f)) else $error("direct call figure wrong");
  a_call_indirect: assert property (s_accept ##0 req.op == cycle_timing_pkg::OP_CALL_NEAR_INDIRECT
    |=> cycles == (BUS8 ? (req_q.mem ? 8'h1b : 8'h11) : (req_q.mem ? 8'h13 : 8'h0d)))
    else $error("indirect call figure wrong");
  a_overflow_trap: assert property (s_accept ##0 req.op == cycle_timing_pkg::OP_INT_OVERFLOW
    |=> trap_taken == req_q.ovf && cycles == (req_q.ovf ? 8'h30 : 8'h04))
    else $error("overflow trap timing wrong");
  a_bound_range: assert property (s_accept ##0 req.op == cycle_timing_pkg::OP_BOUND_CHECK
    |=> cycles >= 8'h21 && cycles <= 8'h23 && cycles == ((req_q.bound_extra == 2'h3) ? 8'h23 : 8'h21 + req_q.bound_extra))
    else $error("bound check outside 33 to 35");
  a_len_matches: assert property (done |-> len_q == cycles)
    else $error("busy length differs from cycle figure");
  a_done_pulse: assert property ($fell(busy) |-> done ##1 !done)
    else $error("done not a single pulse after busy");
  a_busy_refuse: assert property (start && busy |=> $stable(cycles) && $stable(trap_taken))
    else $error("request taken while busy");
endmodule : instruction_cycle_timing_asserts

bind instruction_cycle_timing instruction_cycle_timing_asserts #(.BUS8(BUS8)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .req(req),
  .busy(busy), .done(done), .trap_taken(trap_taken), .cycles(cycles)
);

`default_nettype wire

// >>> dv/instruction_cycle_timing_tb.sv
// Self-checking bench: wide-bus and narrow-bus sequencers against an integer cost model.
// Assumes the package and design sources are compiled first.
`timescale 1ns/10ps
`default_nettype none

module instruction_cycle_timing_tb;
  logic                                   clk_sys = 1'b0;
  logic                                   rst_n = 1'b0;
  logic [1:0]                             start_s = 2'h0;
  cycle_timing_pkg::req_t                 req_s [2] = '{default: '0};
  wire logic [1:0]                        busy_v;
  wire logic [1:0]                        done_v;
  wire logic [1:0]                        trap_v;
  wire logic [cycle_timing_pkg::CNT_W-1:0] cyc_v [2];
  int                                     n_errors = 0;
  int                                     total_checks = 0;
  logic [15:0]                            lfsr_q = 16'h0030;
  cycle_timing_pkg::req_t                 dir_q [$];
  cycle_timing_pkg::op_t                  ops [16] = '{cycle_timing_pkg::OP_ALU_IMM_ACC, cycle_timing_pkg::OP_ALU_IMM_RM,
    cycle_timing_pkg::OP_ALU_RM_REG, cycle_timing_pkg::OP_DEC_RM, cycle_timing_pkg::OP_CALL_NEAR_DIRECT,
    cycle_timing_pkg::OP_CALL_NEAR_INDIRECT, cycle_timing_pkg::OP_INT_OVERFLOW, cycle_timing_pkg::OP_BOUND_CHECK,
    cycle_timing_pkg::OP_CMP_IMM_RM, cycle_timing_pkg::OP_STR_COMPARE, cycle_timing_pkg::OP_INC_RM,
    cycle_timing_pkg::OP_DIV_MEM_WORD, cycle_timing_pkg::OP_IN_FIXED, cycle_timing_pkg::OP_IN_VARIABLE,
    cycle_timing_pkg::OP_CALL_FAR_DIRECT, cycle_timing_pkg::OP_INC_DEC_REG};

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Instance 0 is the wide bus, instance 1 the narrow bus
  instruction_cycle_timing #(.BUS8(1'b0)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start_s[0]),
    .req(req_s[0]), .busy(busy_v[0]), .done(done_v[0]), .trap_taken(trap_v[0]), .cycles(cyc_v[0]));
  instruction_cycle_timing #(.BUS8(1'b1)) dut_n_u (.clk_sys(clk_sys), .rst_n(rst_n), .start(start_s[1]),
    .req(req_s[1]), .busy(busy_v[1]), .done(done_v[1]), .trap_taken(trap_v[1]), .cycles(cyc_v[1]));

  // Fields packed as word, mem, ovf, bound_extra[1:0], mem_xfers[2:0]
  function automatic cycle_timing_pkg::req_t mk(input cycle_timing_pkg::op_t op, input logic [7:0] f);
    return {op, f};
  endfunction : mk

  // Reference cost from plain integers
  function automatic int cost(input cycle_timing_pkg::req_t r, input bit nb);
    int b;
    bit fl;
    fl = 1'b0;
    case (r.op)
      cycle_timing_pkg::OP_ALU_IMM_ACC: b = r.word ? 4 : 3;
      cycle_timing_pkg::OP_ALU_IMM_RM: begin b = r.mem ? 16 : 4; fl = 1'b1; end
      cycle_timing_pkg::OP_ALU_RM_REG: begin b = r.mem ? 10 : 3; fl = 1'b1; end
      cycle_timing_pkg::OP_DEC_RM: begin b = r.mem ? (nb ? 15 : 14) : 3; fl = 1'b1; end
      cycle_timing_pkg::OP_CMP_IMM_RM: begin b = r.mem ? 10 : 3; fl = 1'b1; end
      cycle_timing_pkg::OP_STR_COMPARE: begin b = 22; fl = 1'b1; end
      cycle_timing_pkg::OP_INC_RM: begin b = r.mem ? 15 : 3; fl = 1'b1; end
      cycle_timing_pkg::OP_DIV_MEM_WORD: begin b = 44; fl = 1'b1; end
      cycle_timing_pkg::OP_IN_FIXED: begin b = 10; fl = 1'b1; end
      cycle_timing_pkg::OP_IN_VARIABLE: begin b = 8; fl = 1'b1; end
      cycle_timing_pkg::OP_CALL_FAR_DIRECT: b = nb ? 31 : 23;
      cycle_timing_pkg::OP_INC_DEC_REG: b = 3;
      cycle_timing_pkg::OP_CALL_NEAR_DIRECT: b = nb ? 19 : 15;
      cycle_timing_pkg::OP_CALL_NEAR_INDIRECT: b = r.mem ? (nb ? 27 : 19) : (nb ? 17 : 13);
      cycle_timing_pkg::OP_INT_OVERFLOW: b = r.ovf ? 48 : 4;
      default: b = (r.bound_extra == 3) ? 35 : 33 + r.bound_extra;
    endcase
    if (fl && nb && r.word && r.mem) begin
      b += 4 * r.mem_xfers;
    end
    return b;
  endfunction : cost

  // Next value of the 16-bit stimulus shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check

  // One request; optional refused start in mid-run; random junk on req while busy
  task automatic run_op(input int i, input cycle_timing_pkg::req_t r, input bit poke);
    int n;
    int e;
    e = cost(r, i == 1);
    n = 0;
    start_s[i] = 1'b1;
    req_s[i] = r;
    @(posedge clk_sys);
    #1;
    while (busy_v[i] === 1'b1 && n < 200) begin
      n++;
      lfsr_q = lfsr_next(lfsr_q);
      start_s[i] = poke && n == 2;
      req_s[i] = cycle_timing_pkg::req_t'(lfsr_q[13:0]);
      @(posedge clk_sys);
      #1;
    end
    start_s[i] = 1'b0;
    check(n, e);
    check(cyc_v[i], e);
    check(done_v[i], 1);
    check(trap_v[i], r.op == cycle_timing_pkg::OP_INT_OVERFLOW && r.ovf);
  endtask : run_op

  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #100us;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence; directed runs are back-to-back on purpose
  initial begin
    dir_q = '{mk(ops[0], 8'h00), mk(ops[0], 8'hc7), mk(ops[4], 8'h00), mk(ops[5], 8'h00), mk(ops[5], 8'h40),
      mk(ops[6], 8'h20), mk(ops[6], 8'h00), mk(ops[7], 8'h00), mk(ops[7], 8'h08), mk(ops[7], 8'h10),
      mk(ops[7], 8'h18), mk(ops[1], 8'hc7), mk(ops[1], 8'hc0), mk(ops[2], 8'h43), mk(ops[3], 8'hc2)};
    repeat (12) @(posedge clk_sys);
    #1;
    check({busy_v, done_v, trap_v}, 0);
    rst_n = 1'b1;
    for (int i = 0; i < 2; i++) begin
      foreach (dir_q[k]) begin
        run_op(i, dir_q[k], k == 2);
      end
    end
    $display("test directed done");
    for (int k = 0; k < 64; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      run_op(k % 2, mk(ops[lfsr_q[3:0]], lfsr_q[11:4]), k % 5 == 0);
    end
    $display("test random done");
    // Reset while busy must clear every output
    start_s[1] = 1'b1;
    req_s[1] = mk(ops[7], 8'h10);
    @(posedge clk_sys);
    #1;
    start_s[1] = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst_n = 1'b0;
    #1;
    check({busy_v, done_v, trap_v}, 0);
    check(cyc_v[1], 0);
    @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    run_op(1, mk(ops[6], 8'h20), 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : instruction_cycle_timing_tb

`default_nettype wire
